// File: design/asss_regs.svh
// Constants of the analog sensor status and safe-state block.
// Assumes inclusion by bare name from the design module only.
`ifndef ASSS_REGS_SVH
`define ASSS_REGS_SVH

// Service codes
`define ASSS_SVC_GET        8'h0e
`define ASSS_SVC_SET        8'h10

// Attribute identifiers
`define ASSS_ATTR_UNITS     8'h04
`define ASSS_ATTR_VALID     8'h05
`define ASSS_ATTR_VALUE     8'h06
`define ASSS_ATTR_STATUS    8'h07
`define ASSS_ATTR_FSCALE    8'h0a
`define ASSS_ATTR_SSTATE    8'h19
`define ASSS_ATTR_SVALUE    8'h1a
`define ASSS_ATTR_OVER      8'h20
`define ASSS_ATTR_UNDER     8'h21
`define ASSS_ATTR_WARN      8'h5e
`define ASSS_ATTR_ALARM     8'h5f
`define ASSS_ATTR_EXT       8'h60

// Answer codes
`define ASSS_ERR_NONE       8'h00
`define ASSS_ERR_SVC        8'h08
`define ASSS_ERR_VALUE      8'h09
`define ASSS_ERR_STATE      8'h0c
`define ASSS_ERR_RO         8'h0e
`define ASSS_ERR_ATTR       8'h14

// Exception status byte bits
`define ASSS_STAT_HI_ALM    0
`define ASSS_STAT_LO_ALM    1
`define ASSS_STAT_HI_WRN    2
`define ASSS_STAT_LO_WRN    3

// Sensor alarm word bits
`define ASSS_ALM_ELEC       9
`define ASSS_ALM_LO         14
`define ASSS_ALM_HI         15

// Sensor warning word bits
`define ASSS_WRN_TEMP       0
`define ASSS_WRN_ELEC       9
`define ASSS_WRN_LO         14
`define ASSS_WRN_HI         15

// Status extension bits
`define ASSS_EXT_INVALID    0
`define ASSS_EXT_OVER       1
`define ASSS_EXT_UNDER      2

// Reset values and units codes
`define ASSS_SVALUE_RST     16'h0000
`define ASSS_UNITS_COUNTS   8'h00
`define ASSS_UNITS_SCALED   8'h01

`endif

// File: design/asss_pkg.sv
// Types of the analog sensor status and safe-state block.
// Assumes nothing of its surroundings.
package asss_pkg;

	typedef enum logic [1:0] {
		ASSS_OBJ_EXEC  = 2'b00,
		ASSS_OBJ_IDLE  = 2'b01,
		ASSS_OBJ_FAULT = 2'b10,
		ASSS_OBJ_ABORT = 2'b11
	} asss_obj_state_t;

	typedef enum logic [1:0] {
		ASSS_SAFE_ZERO  = 2'b00,
		ASSS_SAFE_FULL  = 2'b01,
		ASSS_SAFE_HOLD  = 2'b10,
		ASSS_SAFE_VALUE = 2'b11
	} asss_safe_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  service;
		logic [7:0]  attr;
		logic [15:0] data;
	} asss_req_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  code;
		logic [15:0] data;
	} asss_rsp_t;

	typedef struct packed {
		logic high_alarm;
		logic low_alarm;
		logic high_warn;
		logic low_warn;
		logic elec_fail;
		logic elec_warn;
		logic not_at_temp;
	} asss_cond_t;

	typedef struct packed {
		logic [7:0] alarm0;
		logic [7:0] alarm1;
		logic [7:0] warn0;
		logic [7:0] warn1;
		logic [7:0] warn2;
	} asss_detail_t;

endpackage

// File: design/asss_sensor.sv
// Status, exception detail and safe-state value logic of an analog sensor object.
// Assumes raw reading, object state and conditions come from logic on SYS_CLK,
// and that attribute services arrive as one-cycle requests.
`include "asss_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module asss_sensor #(
	parameter logic signed [15:0] FULL_SCALE = 16'sh7fff,
	parameter logic signed [15:0] OVERRANGE  = 16'sh7fff,
	parameter logic signed [15:0] UNDERRANGE = 16'sh8000,
	parameter logic signed [15:0] GAIN       = 16'sh0001,
	parameter logic signed [15:0] OFFSET     = 16'sh0000,
	parameter int unsigned        SHIFT      = 0
) (
	// Clock and reset
	input  wire logic                   SYS_CLK,
	input  wire logic                   RST,
	// Sensor side
	input  wire logic signed [15:0]     RAW_READING,
	input  wire asss_pkg::asss_obj_state_t OBJ_STATE,
	input  wire asss_pkg::asss_cond_t   COND,
	// Attribute services
	input  wire asss_pkg::asss_req_t    REQ,
	output var  asss_pkg::asss_rsp_t    RSP,
	// Reported state
	output logic signed [15:0]          VALUE,
	output logic                        READING_VALID,
	output logic [7:0]                  STATUS,
	output var  asss_pkg::asss_detail_t DETAIL
);

	generate
		if (SHIFT > 15) begin : g_bad_shift
			$error("SHIFT must be 15 or less");
		end
		if (OVERRANGE < UNDERRANGE) begin : g_bad_range
			$error("OVERRANGE below UNDERRANGE");
		end
	endgenerate

	// Conversion, combinational on the raw reading
	logic signed [31:0] product;
	logic signed [31:0] shifted;
	logic signed [15:0] converted;
	logic               over_now;
	logic               under_now;

	// Configuration group
	asss_pkg::asss_safe_t safe_state_r;
	asss_pkg::asss_safe_t safe_state_nxt;
	logic signed [15:0]   safe_value_r;
	logic signed [15:0]   safe_value_nxt;
	logic [7:0]           units_r;
	logic [7:0]           units_nxt;

	// Value group
	logic signed [15:0]   value_r;
	logic signed [15:0]   value_nxt;
	logic signed [15:0]   hold_r;
	logic signed [15:0]   hold_nxt;
	logic                 executing;

	// Status group
	logic                 valid_r;
	logic                 valid_nxt;
	logic [7:0]           status_r;
	logic [7:0]           status_nxt;
	logic [15:0]          alarm_r;
	logic [15:0]          alarm_nxt;
	logic [15:0]          warn_r;
	logic [15:0]          warn_nxt;
	logic [7:0]           ext_r;
	logic [7:0]           ext_nxt;

	// Service group
	asss_pkg::asss_rsp_t  rsp_r;
	asss_pkg::asss_rsp_t  rsp_nxt;
	logic                 wr_sstate;
	logic                 wr_svalue;
	logic                 wr_units;

	// Scaled path: gain, shift, offset; counts pass untouched
	always_comb begin
		product   = 32'(RAW_READING) * 32'(GAIN);
		shifted   = product >>> SHIFT;
		if (units_r == `ASSS_UNITS_COUNTS) begin
			converted = RAW_READING;
		end else begin
			converted = shifted[15:0] + OFFSET;
		end
		// Wraps on extreme gains; limits compare the reported form
		over_now  = converted > OVERRANGE;
		under_now = converted < UNDERRANGE;
	end

	assign executing = (OBJ_STATE == asss_pkg::ASSS_OBJ_EXEC);

	// Configuration writes
	always_comb begin
		safe_state_nxt = safe_state_r;
		safe_value_nxt = safe_value_r;
		units_nxt      = units_r;
		if (wr_sstate) begin
			safe_state_nxt = asss_pkg::asss_safe_t'(REQ.data[1:0]);
		end
		if (wr_svalue) begin
			safe_value_nxt = REQ.data;
		end
		if (wr_units) begin
			units_nxt = REQ.data[7:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			safe_state_r <= asss_pkg::ASSS_SAFE_ZERO;
			safe_value_r <= `ASSS_SVALUE_RST;
			units_r      <= `ASSS_UNITS_COUNTS;
		end else begin
			safe_state_r <= safe_state_nxt;
			safe_value_r <= safe_value_nxt;
			units_r      <= units_nxt;
		end
	end

	// Reported value and hold register
	always_comb begin
		// Tracks while executing, so it holds the final executing value afterwards
		hold_nxt = executing ? converted : hold_r;
		if (executing) begin
			value_nxt = converted;
		end else begin
			case (safe_state_r)
				asss_pkg::ASSS_SAFE_ZERO:  value_nxt = 16'sh0000;
				asss_pkg::ASSS_SAFE_FULL:  value_nxt = FULL_SCALE;
				asss_pkg::ASSS_SAFE_HOLD:  value_nxt = hold_r;
				asss_pkg::ASSS_SAFE_VALUE: value_nxt = safe_value_r;
				default:                   value_nxt = 16'sh0000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			value_r <= 16'sh0000;
			hold_r  <= 16'sh0000;
		end else begin
			value_r <= value_nxt;
			hold_r  <= hold_nxt;
		end
	end

	// Status words, rebuilt every cycle from live conditions
	always_comb begin
		valid_nxt = ~(over_now | under_now);
		status_nxt = 8'h00;
		status_nxt[`ASSS_STAT_HI_ALM] = COND.high_alarm;
		status_nxt[`ASSS_STAT_LO_ALM] = COND.low_alarm;
		status_nxt[`ASSS_STAT_HI_WRN] = COND.high_warn;
		status_nxt[`ASSS_STAT_LO_WRN] = COND.low_warn;
		alarm_nxt = 16'h0000;
		alarm_nxt[`ASSS_ALM_HI]   = COND.high_alarm;
		alarm_nxt[`ASSS_ALM_LO]   = COND.low_alarm;
		alarm_nxt[`ASSS_ALM_ELEC] = COND.elec_fail;
		warn_nxt = 16'h0000;
		warn_nxt[`ASSS_WRN_TEMP] = COND.not_at_temp;
		warn_nxt[`ASSS_WRN_HI]   = COND.high_warn;
		warn_nxt[`ASSS_WRN_LO]   = COND.low_warn;
		warn_nxt[`ASSS_WRN_ELEC] = COND.elec_warn;
		ext_nxt = 8'h00;
		// Same source as valid_nxt, so the pair never disagrees
		ext_nxt[`ASSS_EXT_INVALID] = ~valid_nxt;
		ext_nxt[`ASSS_EXT_OVER]    = over_now;
		ext_nxt[`ASSS_EXT_UNDER]   = under_now;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			valid_r  <= 1'b0;
			status_r <= 8'h00;
			alarm_r  <= 16'h0000;
			warn_r   <= 16'h0000;
			ext_r    <= 8'h01;
		end else begin
			valid_r  <= valid_nxt;
			status_r <= status_nxt;
			alarm_r  <= alarm_nxt;
			warn_r   <= warn_nxt;
			ext_r    <= ext_nxt;
		end
	end

	// Attribute services; one answer the cycle after each request
	always_comb begin
		rsp_nxt       = '0;
		wr_sstate     = 1'b0;
		wr_svalue     = 1'b0;
		wr_units      = 1'b0;
		rsp_nxt.valid = REQ.valid;
		rsp_nxt.code  = `ASSS_ERR_NONE;
		if (!REQ.valid) begin
			rsp_nxt.valid = 1'b0;
		end else if (REQ.service == `ASSS_SVC_GET) begin
			if (REQ.attr == `ASSS_ATTR_UNITS) begin
				rsp_nxt.data = {8'h00, units_r};
			end else if (REQ.attr == `ASSS_ATTR_VALID) begin
				rsp_nxt.data = {15'h0000, valid_r};
			end else if (REQ.attr == `ASSS_ATTR_VALUE) begin
				rsp_nxt.data = value_r;
			end else if (REQ.attr == `ASSS_ATTR_STATUS) begin
				rsp_nxt.data = {8'h00, status_r};
			end else if (REQ.attr == `ASSS_ATTR_FSCALE) begin
				rsp_nxt.data = FULL_SCALE;
			end else if (REQ.attr == `ASSS_ATTR_SSTATE) begin
				rsp_nxt.data = {14'h0000, safe_state_r};
			end else if (REQ.attr == `ASSS_ATTR_SVALUE) begin
				rsp_nxt.data = safe_value_r;
			end else if (REQ.attr == `ASSS_ATTR_OVER) begin
				rsp_nxt.data = OVERRANGE;
			end else if (REQ.attr == `ASSS_ATTR_UNDER) begin
				rsp_nxt.data = UNDERRANGE;
			end else if (REQ.attr == `ASSS_ATTR_WARN) begin
				rsp_nxt.data = warn_r;
			end else if (REQ.attr == `ASSS_ATTR_ALARM) begin
				rsp_nxt.data = alarm_r;
			end else if (REQ.attr == `ASSS_ATTR_EXT) begin
				rsp_nxt.data = {8'h00, ext_r};
			end else begin
				rsp_nxt.code = `ASSS_ERR_ATTR;
			end
		end else if (REQ.service == `ASSS_SVC_SET) begin
			if (REQ.attr == `ASSS_ATTR_SSTATE) begin
				// Only codes 0 to 3 are defined
				if (REQ.data[15:2] != 14'h0000) begin
					rsp_nxt.code = `ASSS_ERR_VALUE;
				end else begin
					wr_sstate = 1'b1;
				end
			end else if (REQ.attr == `ASSS_ATTR_SVALUE) begin
				wr_svalue = 1'b1;
			end else if (REQ.attr == `ASSS_ATTR_UNITS) begin
				// Units change only while idle
				if (OBJ_STATE != asss_pkg::ASSS_OBJ_IDLE) begin
					rsp_nxt.code = `ASSS_ERR_STATE;
				end else if (REQ.data[15:8] != 8'h00 ||
				             REQ.data[7:0] > `ASSS_UNITS_SCALED) begin
					rsp_nxt.code = `ASSS_ERR_VALUE;
				end else begin
					wr_units = 1'b1;
				end
			end else if (REQ.attr == `ASSS_ATTR_VALID || REQ.attr == `ASSS_ATTR_VALUE ||
			             REQ.attr == `ASSS_ATTR_STATUS || REQ.attr == `ASSS_ATTR_FSCALE ||
			             REQ.attr == `ASSS_ATTR_OVER || REQ.attr == `ASSS_ATTR_UNDER ||
			             REQ.attr == `ASSS_ATTR_WARN || REQ.attr == `ASSS_ATTR_ALARM ||
			             REQ.attr == `ASSS_ATTR_EXT) begin
				// Status byte included: reserved bits cannot be changed
				rsp_nxt.code = `ASSS_ERR_RO;
			end else begin
				rsp_nxt.code = `ASSS_ERR_ATTR;
			end
		end else begin
			rsp_nxt.code = `ASSS_ERR_SVC;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	// Outputs and exception detail mapping
	assign RSP           = rsp_r;
	assign VALUE         = value_r;
	assign READING_VALID = valid_r;
	assign STATUS        = status_r;
	assign DETAIL.alarm0 = alarm_r[7:0];
	assign DETAIL.alarm1 = alarm_r[15:8];
	assign DETAIL.warn0  = ext_r;
	assign DETAIL.warn1  = warn_r[7:0];
	assign DETAIL.warn2  = warn_r[15:8];

endmodule

`default_nettype wire

// File: bench/asss_sensor_monitor.sv
// Checker of the analog sensor status and safe-state block.
// Assumes one clock and a synchronous active-high reset; sees top ports only.
`timescale 1ns/10ps
`default_nettype none

module asss_sensor_monitor (
	// Clock and reset
	input wire logic                     SYS_CLK,
	input wire logic                     RST,
	// Sensor side
	input wire logic signed [15:0]       RAW_READING,
	input wire asss_pkg::asss_obj_state_t OBJ_STATE,
	input wire asss_pkg::asss_cond_t     COND,
	// Services
	input wire asss_pkg::asss_req_t      REQ,
	input wire asss_pkg::asss_rsp_t      RSP,
	// Reported state
	input wire logic signed [15:0]       VALUE,
	input wire logic                     READING_VALID,
	input wire logic [7:0]               STATUS,
	input wire asss_pkg::asss_detail_t   DETAIL
);
	logic [7:0] st_x;
	logic [7:0] a1_x;
	logic [7:0] w2_x;
	assign st_x = {4'h0, COND.low_warn, COND.high_warn, COND.low_alarm, COND.high_alarm};
	assign a1_x = {COND.high_alarm, COND.low_alarm, 4'h0, COND.elec_fail, 1'b0};
	assign w2_x = {COND.high_warn, COND.low_warn, 4'h0, COND.elec_warn, 1'b0};
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence s_req; REQ.valid; endsequence
	sequence s_get_stat; REQ.valid && REQ.service == 8'h0e && REQ.attr == 8'h07; endsequence
	property p_stat_map; !$past(RST) |-> STATUS == $past(st_x); endproperty
	a_stat_map: assert property (p_stat_map) else $error("status bits off");
	property p_stat_rsvd; STATUS[7:4] == 4'h0; endproperty
	a_stat_rsvd: assert property (p_stat_rsvd) else $error("status upper bits set");
	property p_alarm;
		!$past(RST) |-> DETAIL.alarm0 == 8'h00 && DETAIL.alarm1 == $past(a1_x);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm detail off");
	property p_warn;
		!$past(RST) |-> DETAIL.warn1 == {7'h0, $past(COND.not_at_temp)}
			&& DETAIL.warn2 == $past(w2_x);
	endproperty
	a_warn: assert property (p_warn) else $error("warning detail off");
	property p_ext; DETAIL.warn0 == {5'h0, DETAIL.warn0[2:1], !READING_VALID}; endproperty
	a_ext: assert property (p_ext) else $error("status extension off");
	property p_valid_range;
		!$past(RST) |-> READING_VALID == !(DETAIL.warn0[1] || DETAIL.warn0[2]);
	endproperty
	a_valid_range: assert property (p_valid_range) else $error("valid flag off");
	// Any safe choice gives a constant value while config and state sit still
	property p_safe_stable;
		!$past(RST) && !$past(RST, 2) && !$past(REQ.valid, 2)
			&& $past(OBJ_STATE) != asss_pkg::ASSS_OBJ_EXEC
			&& $past(OBJ_STATE, 2) != asss_pkg::ASSS_OBJ_EXEC |-> $stable(VALUE);
	endproperty
	a_safe_stable: assert property (p_safe_stable) else $error("safe value moved");
	property p_answer; s_req |=> RSP.valid ##1 !RSP.valid || $past(REQ.valid); endproperty
	a_answer: assert property (p_answer) else $error("answer missing");
	property p_get_stat; s_get_stat |=> RSP.code == 8'h00 && RSP.data[15:4] == 12'h000; endproperty
	a_get_stat: assert property (p_get_stat) else $error("status read bad");
endmodule

bind asss_sensor asss_sensor_monitor i_mon (.SYS_CLK(SYS_CLK), .RST(RST),
	.RAW_READING(RAW_READING), .OBJ_STATE(OBJ_STATE), .COND(COND), .REQ(REQ),
	.RSP(RSP), .VALUE(VALUE), .READING_VALID(READING_VALID), .STATUS(STATUS),
	.DETAIL(DETAIL));
`default_nettype wire

// File: bench/asss_master_model.sv
// Network master model issuing get and set attribute services.
// Assumes one-cycle requests taken at the next rising edge of SYS_CLK.
`timescale 1ns/10ps
`default_nettype none

module asss_master_model (
	// Clock
	input wire logic                SYS_CLK,
	// Services
	output var asss_pkg::asss_req_t REQ,
	input wire asss_pkg::asss_rsp_t RSP
);
	initial REQ = '0;
	// Code ff back means no answer came within the bound
	task automatic xfer(input logic [7:0] svc, input logic [7:0] attr, input logic [15:0] wd,
		output logic [7:0] code, output logic [15:0] rd);
		int n;
		code = 8'hff;
		rd = 16'h0000;
		REQ <= '{1'b1, svc, attr, wd};
		@(posedge SYS_CLK);
		// Released fields are inverted so stale values never pass
		REQ <= '{1'b0, ~svc, ~attr, ~wd};
		for (n = 0; n < 4; n++) begin
			@(posedge SYS_CLK);
			if (RSP.valid === 1'b1) begin
				code = RSP.code;
				rd = RSP.data;
				break;
			end
		end
	endtask
endmodule
`default_nettype wire

// File: bench/analog_sensor_status_safe_state_tb_top.sv
// Testbench of the analog sensor status and safe-state block.
// Assumes the design, its package and the master model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module analog_sensor_status_safe_state_tb_top;
	localparam logic signed [15:0] FS = 16'sh7000;
	logic                      SYS_CLK;
	logic                      RST;
	logic signed [15:0]        RAW_READING;
	asss_pkg::asss_obj_state_t OBJ_STATE;
	asss_pkg::asss_cond_t      COND;
	asss_pkg::asss_req_t       REQ;
	asss_pkg::asss_rsp_t       RSP;
	logic signed [15:0]        VALUE;
	logic                      READING_VALID;
	logic [7:0]                STATUS;
	asss_pkg::asss_detail_t    DETAIL;
	asss_pkg::asss_cond_t      c;
	logic [15:0]               expv [4];
	int                        fails;
	int                        total_checks;
	int                        i;

	asss_sensor #(.FULL_SCALE(FS), .OVERRANGE(16'sh1000), .UNDERRANGE(16'shff00),
		.GAIN(16'sh0003), .OFFSET(16'sh0010), .SHIFT(1)) i_dut (.SYS_CLK(SYS_CLK),
		.RST(RST), .RAW_READING(RAW_READING), .OBJ_STATE(OBJ_STATE), .COND(COND),
		.REQ(REQ), .RSP(RSP), .VALUE(VALUE), .READING_VALID(READING_VALID),
		.STATUS(STATUS), .DETAIL(DETAIL));
	asss_master_model i_master (.SYS_CLK(SYS_CLK), .REQ(REQ), .RSP(RSP));

	initial begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	task automatic step(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic svc(input logic [7:0] s, input logic [7:0] a, input logic [15:0] wd,
		input logic [7:0] ecode, input logic [15:0] erd);
		logic [7:0]  code;
		logic [15:0] rd;
		i_master.xfer(s, a, wd, code, rd);
		if (code === 8'hff) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, code, ecode);
			test_done();
		end else begin
			chk(40'(code), 40'(ecode));
			chk(40'(rd), 40'(erd));
		end
	endtask

	initial begin
		RST = 1'b1;
		RAW_READING = 16'sh0123;
		OBJ_STATE = asss_pkg::ASSS_OBJ_EXEC;
		COND = '0;
		fails = 0;
		total_checks = 0;
		expv = '{16'h0000, FS, 16'h0222, 16'h0bad};
		step(20);
		chk(40'(DETAIL), 40'h0000010000);
		RST <= 1'b0;
		step(3);
		chk(40'({VALUE, READING_VALID}), 40'h00247);
		// Each condition alone, then all together
		for (i = 0; i < 8; i++) begin
			c = (i < 7) ? asss_pkg::asss_cond_t'(7'h01 << i) : asss_pkg::asss_cond_t'(7'h7f);
			COND <= c;
			step(2);
			chk(40'(STATUS), 40'({4'h0, c.low_warn, c.high_warn, c.low_alarm, c.high_alarm}));
			chk(40'(DETAIL), {8'h00, c.high_alarm, c.low_alarm, 4'h0, c.elec_fail, 1'b0, 8'h00,
				7'h00, c.not_at_temp, c.high_warn, c.low_warn, 4'h0, c.elec_warn, 1'b0});
		end
		svc(8'h0e, 8'h07, 16'h0000, 8'h00, 16'h000f);
		svc(8'h10, 8'h07, 16'h00f0, 8'h0e, 16'h0000);
		svc(8'h0e, 8'h07, 16'h0000, 8'h00, 16'h000f);
		COND <= '0;
		for (i = 0; i < 4; i++) begin
			svc(8'h10, 8'h1a, 16'h0bad, 8'h00, 16'h0000);
			svc(8'h10, 8'h19, 16'(i), 8'h00, 16'h0000);
			RAW_READING <= 16'sh0222;
			OBJ_STATE <= asss_pkg::ASSS_OBJ_EXEC;
			step(3);
			RAW_READING <= 16'sh0333;
			OBJ_STATE <= asss_pkg::asss_obj_state_t'((i == 0) ? 1 : i);
			step(3);
			chk(40'(VALUE), 40'(expv[i]));
		end
		svc(8'h0e, 8'h19, 16'h0000, 8'h00, 16'h0003);
		svc(8'h10, 8'h19, 16'h0004, 8'h09, 16'h0000);
		svc(8'h4b, 8'h06, 16'h0000, 8'h08, 16'h0000);
		OBJ_STATE <= asss_pkg::ASSS_OBJ_EXEC;
		RAW_READING <= 16'sh2000;
		step(2);
		chk(40'({READING_VALID, DETAIL.warn0}), 40'h003);
		RAW_READING <= 16'shfe00;
		step(2);
		chk(40'({READING_VALID, DETAIL.warn0}), 40'h005);
		OBJ_STATE <= asss_pkg::ASSS_OBJ_IDLE;
		step(2);
		svc(8'h10, 8'h04, 16'h0001, 8'h00, 16'h0000);
		OBJ_STATE <= asss_pkg::ASSS_OBJ_EXEC;
		RAW_READING <= 16'sh0100;
		step(3);
		chk(40'({VALUE, READING_VALID}), 40'h00321);
		svc(8'h0e, 8'h06, 16'h0000, 8'h00, 16'h0190);
		svc(8'h0e, 8'h05, 16'h0000, 8'h00, 16'h0001);
		COND <= asss_pkg::asss_cond_t'(7'h7f);
		step(2);
		svc(8'h0e, 8'h5f, 16'h0000, 8'h00, 16'hc200);
		svc(8'h0e, 8'h5e, 16'h0000, 8'h00, 16'hc201);
		svc(8'h0e, 8'h60, 16'h0000, 8'h00, 16'h0000);
		svc(8'h10, 8'h04, 16'h0000, 8'h0c, 16'h0000);
		svc(8'h0e, 8'h33, 16'h0000, 8'h14, 16'h0000);
		// Mid-run reset must put units and safe state back
		RST <= 1'b1;
		step(2);
		RST <= 1'b0;
		step(1);
		svc(8'h0e, 8'h04, 16'h0000, 8'h00, 16'h0000);
		svc(8'h0e, 8'h19, 16'h0000, 8'h00, 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire
